// ---- rtl/lpd_field_dec.sv ----
// Overview of operation
// - line address = adapter plus selector bits 2-6
// - fast board gives 64 plus 32 lines
// - first family bit 2 picks board half
// - first family bits 3-4 pick card
// - first family bits 5-6 pick port
// - quad-port card accepts all four ports
// - single-port card accepts first port only
// - bit 7 set means receive, clear transmit
// - second family bit 2 picks board
// - second family bits 3-5 pick card
// - second family bit 6 picks port
// - two-port answers both, single-port first only
// - second family lines start at 64
package lpd_pkg;
    // ********************************
    // selector byte field positions
    // ********************************
    localparam int SEL_DIR_BIT   = 0;
    localparam int SEL_PORT1_LSB = 1;
    localparam int SEL_PORT2_BIT = 1;
    localparam int SEL_CARD1_LSB = 3;
    localparam int SEL_CARD2_LSB = 2;
    localparam int SEL_HALF_BIT  = 5;
    localparam int SEL_TOP_LSB   = 6;
    localparam int SEL_LINE_LSB  = 1;
    // ********************************
    // line numbering
    // ********************************
    localparam int         NUM_LINES     = 96;
    localparam logic [6:0] LINE_BASE_F2  = 7'h40;
    // ********************************
    // register map and reset values
    // ********************************
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_SINGLE1 = 8'h04;
    localparam logic [7:0] OFF_SINGLE2 = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_HIT0   = 8'h10;
    localparam logic [7:0] OFF_HIT1   = 8'h14;
    localparam logic [7:0] OFF_HIT2   = 8'h18;
    localparam logic [7:0] OFF_COUNT  = 8'h1C;
    localparam logic        RST_FAST    = 1'b1;
    localparam logic [15:0] RST_SINGLE  = 16'h0000;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    // ********************************
    // bus state machines
    // ********************************
    typedef enum logic [1:0] {
        LPD_W_IDLE = 2'b01,
        LPD_W_RESP = 2'b10
    } lpd_wst_t;
    typedef enum logic [1:0] {
        LPD_R_IDLE = 2'b01,
        LPD_R_DATA = 2'b10
    } lpd_rst_t;
endpackage

`timescale 1ns/1ps
`default_nettype none
module lpd_field_dec
    import lpd_pkg::*;
(
    input  wire logic [7:0]  i_sel,
    input  wire logic        i_fam2,
    input  wire logic        i_bank,
    input  wire logic        i_fast,
    input  wire logic [15:0] i_single1,
    input  wire logic [15:0] i_single2,
    output logic             o_ok,
    output logic [6:0]       o_line,
    output logic             o_rx,
    output logic             o_half,
    output logic [2:0]       o_card,
    output logic [1:0]       o_port
);
    // ********************************
    // selector decode
    // ********************************
    // pure decode; the caller registers it
    always_comb begin
        logic top_zero;
        logic single;
        top_zero = 1'b0;
        single   = 1'b0;
        top_zero = (i_sel[7:SEL_TOP_LSB] == 2'h0);
        o_rx     = i_sel[SEL_DIR_BIT];
        o_half   = i_sel[SEL_HALF_BIT];
        if (!i_fam2) begin
            o_card = {1'b0, i_sel[SEL_CARD1_LSB +: 2]};
            o_port = i_sel[SEL_PORT1_LSB +: 2];
            single = i_single1[{i_bank, o_half, o_card[1:0]}];
            // quad cards take any port, single only the first
            o_ok   = top_zero && (!single || o_port == 2'h0);
            o_line = {1'b0, i_bank, i_sel[SEL_LINE_LSB +: 5]};
        end else begin
            o_card = i_sel[SEL_CARD2_LSB +: 3];
            o_port = {1'b0, i_sel[SEL_PORT2_BIT]};
            single = i_single2[{o_half, o_card}];
            // second family exists only beside the fast board
            o_ok   = top_zero && i_fast
                     && (!single || !o_port[0]);
            o_line = 7'(LINE_BASE_F2 + {2'h0, i_sel[SEL_LINE_LSB +: 5]});
        end
    end
endmodule
`default_nettype wire

// ---- rtl/lpd_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module lpd_top
    import lpd_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // selector byte from the data phase
    input  wire logic        i_sel_valid,
    input  wire logic [7:0]  i_sel_byte,
    input  wire logic        i_sel_fam2,
    input  wire logic        i_sel_bank,
    // decoded line
    output logic             o_line_valid,
    output logic             o_line_reject,
    output logic [6:0]       o_line_num,
    output logic             o_line_rx,
    output logic             o_line_half,
    output logic [2:0]       o_line_card,
    output logic [1:0]       o_line_port,
    // axi4-lite slave
    input  wire logic [7:0]  i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [7:0]  i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready
);
    // ********************************
    // state
    // ********************************
    typedef struct packed {
        lpd_wst_t         wst;
        lpd_rst_t         rst;
        logic             awready;
        logic             wready;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             arready;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
        logic             aw_have;
        logic [7:0]       aw_addr;
        logic             w_have;
        logic [31:0]      w_data;
        logic [3:0]       w_strb;
        logic             fast;
        logic [15:0]      single1;
        logic [15:0]      single2;
        logic [NUM_LINES-1:0] hit;
        logic [15:0]      ok_cnt;
        logic [15:0]      rej_cnt;
        logic             last_rej;
        logic             fam2;
        logic             line_valid;
        logic             line_reject;
        logic [6:0]       line_num;
        logic             line_rx;
        logic             line_half;
        logic [2:0]       line_card;
        logic [1:0]       line_port;
    } lpd_state_t;

    lpd_state_t st;
    lpd_state_t next_st;
    logic       dec_ok;
    logic [6:0] dec_line;
    logic       dec_rx;
    logic       dec_half;
    logic [2:0] dec_card;
    logic [1:0] dec_port;
    logic       wr_do;
    // ********************************
    // selector field decoder
    // ********************************
    lpd_field_dec u_dec (
        .i_sel     (i_sel_byte),
        .i_fam2    (i_sel_fam2),
        .i_bank    (i_sel_bank),
        .i_fast    (st.fast),
        .i_single1 (st.single1),
        .i_single2 (st.single2),
        .o_ok      (dec_ok),
        .o_line    (dec_line),
        .o_rx      (dec_rx),
        .o_half    (dec_half),
        .o_card    (dec_card),
        .o_port    (dec_port)
    );

    // ********************************
    // helpers
    // ********************************
    // byte-lane merge for writable registers
    function automatic logic [31:0] lpd_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction
    // write fires once both halves of the request are held
    assign wr_do = (st.wst == LPD_W_IDLE) && st.aw_have && st.w_have;
    // ********************************
    // next state
    // ********************************
    always_comb begin
        logic [31:0] m;
        logic [7:0]  wa;
        logic [7:0]  ra;
        m   = 32'h0;
        wa  = {st.aw_addr[7:2], 2'b00};
        ra  = {i_araddr[7:2], 2'b00};
        next_st = st;
        next_st.line_valid  = 1'b0;
        next_st.line_reject = 1'b0;
        // address and data may arrive in either order
        if (st.awready && i_awvalid) begin
            next_st.aw_have = 1'b1;
            next_st.aw_addr = i_awaddr;
            next_st.awready = 1'b0;
        end
        if (st.wready && i_wvalid) begin
            next_st.w_have = 1'b1;
            next_st.w_data = i_wdata;
            next_st.w_strb = i_wstrb;
            next_st.wready = 1'b0;
        end
        // write channel
        case (st.wst)
            LPD_W_IDLE: begin
                if (wr_do) begin
                    m = lpd_merge(32'h0, st.w_data, st.w_strb);
                    next_st.bresp = RESP_OKAY;
                    if (wa == OFF_CTRL) begin
                        if (st.w_strb[0]) begin
                            next_st.fast = st.w_data[0];
                        end
                    end else if (wa == OFF_SINGLE1) begin
                        next_st.single1 = 16'(lpd_merge(
                            {16'h0, st.single1}, st.w_data, st.w_strb));
                    end else if (wa == OFF_SINGLE2) begin
                        next_st.single2 = 16'(lpd_merge(
                            {16'h0, st.single2}, st.w_data, st.w_strb));
                    end else if (wa == OFF_HIT0) begin
                        next_st.hit[31:0] = st.hit[31:0] & ~m;
                    end else if (wa == OFF_HIT1) begin
                        next_st.hit[63:32] = st.hit[63:32] & ~m;
                    end else if (wa == OFF_HIT2) begin
                        next_st.hit[95:64] = st.hit[95:64] & ~m;
                    end else if (wa == OFF_STATUS || wa == OFF_COUNT) begin
                        next_st.bresp = RESP_OKAY; // read-only, write ignored
                    end else begin
                        next_st.bresp = RESP_SLVERR;
                    end
                    next_st.aw_have = 1'b0;
                    next_st.w_have  = 1'b0;
                    next_st.bvalid  = 1'b1;
                    next_st.wst     = LPD_W_RESP;
                end
            end
            LPD_W_RESP: begin
                // one write at a time: ready comes back after the answer
                if (i_bready) begin
                    next_st.bvalid  = 1'b0;
                    next_st.awready = 1'b1;
                    next_st.wready  = 1'b1;
                    next_st.wst     = LPD_W_IDLE;
                end
            end
            default: begin
                next_st.wst = LPD_W_IDLE;
            end
        endcase

        // read channel
        case (st.rst)
            LPD_R_IDLE: begin
                if (st.arready && i_arvalid) begin
                    next_st.rresp = RESP_OKAY;
                    if (ra == OFF_CTRL) begin
                        next_st.rdata = {31'h0, st.fast};
                    end else if (ra == OFF_SINGLE1) begin
                        next_st.rdata = {16'h0, st.single1};
                    end else if (ra == OFF_SINGLE2) begin
                        next_st.rdata = {16'h0, st.single2};
                    end else if (ra == OFF_STATUS) begin
                        next_st.rdata = {16'h0, st.fam2, st.last_rej, st.line_port,
                                         st.line_card, st.line_half, st.line_rx, st.line_num};
                    end else if (ra == OFF_HIT0) begin
                        next_st.rdata = st.hit[31:0];
                    end else if (ra == OFF_HIT1) begin
                        next_st.rdata = st.hit[63:32];
                    end else if (ra == OFF_HIT2) begin
                        next_st.rdata = st.hit[95:64];
                    end else if (ra == OFF_COUNT) begin
                        next_st.rdata = {st.rej_cnt, st.ok_cnt};
                    end else begin
                        next_st.rdata = 32'h0;
                        next_st.rresp = RESP_SLVERR;
                    end
                    next_st.rvalid  = 1'b1;
                    next_st.arready = 1'b0;
                    next_st.rst     = LPD_R_DATA;
                end
            end
            LPD_R_DATA: begin
                if (i_rready) begin
                    next_st.rvalid  = 1'b0;
                    next_st.arready = 1'b1;
                    next_st.rst     = LPD_R_IDLE;
                end
            end
            default: begin
                next_st.rst = LPD_R_IDLE;
            end
        endcase

        // selector decode; the set comes after any clear so it wins
        if (i_sel_valid) begin
            if (dec_ok) begin
                next_st.line_valid     = 1'b1;
                next_st.line_num       = dec_line;
                next_st.line_rx        = dec_rx;
                next_st.line_half      = dec_half;
                next_st.line_card      = dec_card;
                next_st.line_port      = dec_port;
                next_st.fam2           = i_sel_fam2;
                next_st.last_rej       = 1'b0;
                next_st.hit[dec_line]  = 1'b1;
                next_st.ok_cnt         = st.ok_cnt + 16'h0001;
            end else begin
                // refused selector: no line, line state left as it was
                next_st.line_reject = 1'b1;
                next_st.last_rej    = 1'b1;
                next_st.rej_cnt     = st.rej_cnt + 16'h0001;
            end
        end
    end

    // ********************************
    // registers
    // ********************************
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st         <= '0;
            st.wst     <= LPD_W_IDLE;
            st.rst     <= LPD_R_IDLE;
            st.awready <= 1'b1;
            st.wready  <= 1'b1;
            st.arready <= 1'b1;
            st.fast    <= RST_FAST;
            st.single1 <= RST_SINGLE;
            st.single2 <= RST_SINGLE;
        end else begin
            st <= next_st;
        end
    end

    // ********************************
    // outputs
    // ********************************
    assign o_line_valid  = st.line_valid;
    assign o_line_reject = st.line_reject;
    assign o_line_num    = st.line_num;
    assign o_line_rx     = st.line_rx;
    assign o_line_half   = st.line_half;
    assign o_line_card   = st.line_card;
    assign o_line_port   = st.line_port;
    assign o_awready     = st.awready;
    assign o_wready      = st.wready;
    assign o_bresp       = st.bresp;
    assign o_bvalid      = st.bvalid;
    assign o_arready     = st.arready;
    assign o_rdata       = st.rdata;
    assign o_rresp       = st.rresp;
    assign o_rvalid      = st.rvalid;

    // ********************************
    // checks
    // ********************************
    default clocking lpd_cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    a_fast_gates_fam2: assert property (
        i_sel_valid && i_sel_fam2 && !st.fast
        |=> o_line_reject && !o_line_valid)
        else $error("second family accepted without fast board");

    a_half_select: assert property (
        i_sel_valid && !i_sel_fam2 && dec_ok
        |=> o_line_half == $past(i_sel_byte[5]))
        else $error("half select wrong");

    a_card1_select: assert property (
        i_sel_valid && !i_sel_fam2 && dec_ok
        |=> o_line_card == {1'b0, $past(i_sel_byte[4:3])})
        else $error("first family card wrong");

    a_port1_select: assert property (
        i_sel_valid && !i_sel_fam2 && dec_ok
        |=> o_line_port == $past(i_sel_byte[2:1]))
        else $error("first family port wrong");

    a_quad_all_ports: assert property (
        i_sel_valid && !i_sel_fam2 && i_sel_byte[7:6] == 2'h0
        && !st.single1[{i_sel_bank, i_sel_byte[5:3]}]
        |=> o_line_valid)
        else $error("quad card port refused");

    a_single1_refuse: assert property (
        i_sel_valid && !i_sel_fam2 && i_sel_byte[2:1] != 2'h0
        && st.single1[{i_sel_bank, i_sel_byte[5:3]}]
        |=> o_line_reject ##1 (!o_line_reject || $past(i_sel_valid)))
        else $error("single card extra port accepted");

    a_dir_follows: assert property (
        i_sel_valid && dec_ok |=> o_line_valid
        && o_line_rx == $past(i_sel_byte[0]))
        else $error("direction bit wrong");

    a_card2_board: assert property (
        i_sel_valid && i_sel_fam2 && dec_ok
        |=> o_line_card == $past(i_sel_byte[4:2])
        && o_line_half == $past(i_sel_byte[5]))
        else $error("second family card or board wrong");

    a_port2_select: assert property (
        i_sel_valid && i_sel_fam2 && dec_ok
        |=> o_line_port == {1'b0, $past(i_sel_byte[1])})
        else $error("second family port wrong");

    a_single2_refuse: assert property (
        i_sel_valid && i_sel_fam2 && i_sel_byte[1]
        && st.single2[i_sel_byte[5:2]] |=> o_line_reject)
        else $error("single card second port accepted");

    a_fam2_base: assert property (
        i_sel_valid && i_sel_fam2 && dec_ok
        |=> o_line_num == 7'($past(i_sel_byte[5:1]) + 7'h40))
        else $error("second family line number wrong");

    a_refuse_keeps: assert property (
        i_sel_valid && !dec_ok && !wr_do
        |=> st.hit == $past(st.hit) && $stable(o_line_num))
        else $error("refused selector changed line state");
endmodule
`default_nettype wire

// ---- verif/lpd_scan_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ********************************
// scanner adapter side of the io bus
// ********************************
module lpd_scan_model (
    input  wire logic       i_clk,
    input  wire logic       i_go,
    input  wire logic [6:0] i_line,
    input  wire logic       i_rx,
    input  wire logic [1:0] i_top,
    output logic            o_valid,
    output logic [7:0]      o_byte,
    output logic            o_fam2,
    output logic            o_bank
);
    // one byte per command, strobed for one cycle; the bench holds go low in reset
    always @(posedge i_clk) begin
        o_valid <= i_go;
        if (i_go) begin
            o_byte <= {i_top, i_line[4:0], i_rx};
            o_fam2 <= i_line[6];
            o_bank <= i_line[5];
        end else begin
            // released lines invert the byte every cycle, so a sample one cycle late shows
            o_byte <= ~o_byte;
        end
    end
endmodule
`default_nettype wire

// ---- verif/lpd_top_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module lpd_top_tb_top;
    import lpd_pkg::*;
    logic        clk, rst_n, go, rx, sel_valid, fam2, bank;
    logic [6:0]  line;
    logic [1:0]  top;
    logic [7:0]  sel_byte, awaddr, araddr;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        o_line_valid, o_line_reject, o_line_rx, o_line_half;
    logic [6:0]  o_line_num;
    logic [2:0]  o_line_card;
    logic [1:0]  o_line_port, o_bresp, o_rresp;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [31:0] o_rdata;
    logic [6:0]  e_line = 7'h00;
    logic [2:0]  e_card = 3'h0;
    logic [1:0]  e_port = 2'h0;
    logic        e_rx = 1'b0, e_half = 1'b0, e_fam2 = 1'b0;
    int          failures = 0, num_checks = 0, acc = 0, rej = 0;

    lpd_scan_model i_lpd_scan_model (.i_clk(clk), .i_go(go), .i_line(line), .i_rx(rx),
        .i_top(top), .o_valid(sel_valid), .o_byte(sel_byte), .o_fam2(fam2), .o_bank(bank));

    lpd_top i_lpd_top (.i_clk(clk), .i_rst_n(rst_n), .i_sel_valid(sel_valid),
        .i_sel_byte(sel_byte), .i_sel_fam2(fam2), .i_sel_bank(bank),
        .o_line_valid(o_line_valid), .o_line_reject(o_line_reject), .o_line_num(o_line_num),
        .o_line_rx(o_line_rx), .o_line_half(o_line_half), .o_line_card(o_line_card),
        .o_line_port(o_line_port), .i_awaddr(awaddr), .i_awvalid(awvalid),
        .o_awready(o_awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
        .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
        .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(rready));

    // ********************************
    // helpers
    // ********************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic close_out;
        if (failures == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // one selector byte through the scanner model; fields only move on accept
    task automatic send(input logic [6:0] ln, input logic r, input logic [1:0] tp,
                        input logic ok);
        logic [7:0] b;
        b = {tp, ln[4:0], r};
        @(posedge clk);
        go <= 1'b1;
        line <= ln;
        rx <= r;
        top <= tp;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        #1;
        if (ok) begin
            e_line = ln;
            e_rx = r;
            e_half = b[5];
            e_fam2 = ln[6];
            e_card = ln[6] ? b[4:2] : {1'b0, b[4:3]};
            e_port = ln[6] ? {1'b0, b[1]} : b[2:1];
            acc++;
        end else begin
            rej++;
        end
        chk({31'h0, o_line_valid}, {31'h0, ok}, "accept pulse");
        chk({31'h0, o_line_reject}, {31'h0, !ok}, "reject pulse");
        chk({o_line_num, o_line_rx, o_line_half, o_line_card, o_line_port},
            {e_line, e_rx, e_half, e_card, e_port}, "line fields");
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (o_awready) awvalid <= 1'b0;
            if (o_wready) wvalid <= 1'b0;
            n++;
        end while (o_bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        if (n >= 50) failures++;
        chk({30'h0, o_bresp}, {30'h0, er}, "write resp");
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (o_arready) arvalid <= 1'b0;
            n++;
        end while (o_rvalid !== 1'b1 && n < 50);
        rready <= 1'b0;
        if (n >= 50) failures++;
        chk(o_rdata, ed, "read data");
        chk({30'h0, o_rresp}, {30'h0, er}, "read resp");
    endtask

    // ********************************
    // tests
    // ********************************
    initial begin
        {rst_n, go, rx, line, top, awaddr, araddr} = '0;
        {awvalid, wvalid, bready, arvalid, rready, wdata} = '0;
        wstrb = 4'hF;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        axi_rd(OFF_CTRL, {31'h0, RST_FAST}, RESP_OKAY);
        chk({16'h0, o_line_valid, o_line_reject, o_line_num, o_line_rx, o_line_half,
             o_line_card, o_line_port}, 32'h0, "reset lines");
        axi_rd(OFF_SINGLE1, {16'h0, RST_SINGLE}, RESP_OKAY);
        axi_rd(OFF_SINGLE2, {16'h0, RST_SINGLE}, RESP_OKAY);
        for (int i = 0; i < 5; i++) begin
            axi_rd(OFF_STATUS + 8'(4 * i), 32'h0, RESP_OKAY);
        end
        axi_rd(8'h20, 32'h0, RESP_SLVERR);
        axi_wr(8'h24, 32'hFFFF_FFFF, RESP_SLVERR);
        // every line both ways; no single-port cards anywhere after reset
        for (int r = 0; r < 2; r++) begin
            for (int l = 0; l < 96; l++) begin
                send(7'(l), r[0], 2'h0, 1'b1);
            end
        end
        for (int i = 0; i < 3; i++) begin
            axi_rd(OFF_HIT0 + 8'(4 * i), 32'hFFFF_FFFF, RESP_OKAY);
        end
        axi_wr(OFF_HIT1, 32'h0000_FFFF, RESP_OKAY);
        axi_rd(OFF_HIT1, 32'hFFFF_0000, RESP_OKAY);
        send(7'd77, 1'b1, 2'h0, 1'b1);
        axi_rd(OFF_STATUS, {16'h0, e_fam2, 1'b0, e_port, e_card, e_half, e_rx, e_line},
               RESP_OKAY);
        // nonzero top bits name no line
        send(7'd3, 1'b0, 2'h1, 1'b0);
        send(7'd3, 1'b0, 2'h2, 1'b0);
        // single-port card in half two, position three: only port one answers
        // only lane 0 enabled: the upper byte must not land
        wstrb <= 4'h1;
        axi_wr(OFF_SINGLE1, 32'h0000_FF40, RESP_OKAY);
        wstrb <= 4'hF;
        axi_rd(OFF_SINGLE1, 32'h0000_0040, RESP_OKAY);
        axi_wr(OFF_HIT0, 32'hFFFF_FFFF, RESP_OKAY);
        send(7'd25, 1'b0, 2'h0, 1'b0);
        send(7'd24, 1'b1, 2'h0, 1'b1);
        axi_rd(OFF_HIT0, 32'h0100_0000, RESP_OKAY);
        // single-port card in the last position of the upper board
        axi_wr(OFF_SINGLE2, 32'h0000_8000, RESP_OKAY);
        send(7'd95, 1'b1, 2'h0, 1'b0);
        send(7'd94, 1'b0, 2'h0, 1'b1);
        // second family exists only with the fast board fitted
        axi_wr(OFF_CTRL, 32'h0, RESP_OKAY);
        send(7'd64, 1'b0, 2'h0, 1'b0);
        send(7'd63, 1'b1, 2'h0, 1'b1);
        axi_wr(OFF_CTRL, 32'h1, RESP_OKAY);
        send(7'd64, 1'b0, 2'h0, 1'b1);
        axi_wr(OFF_COUNT, 32'h0, RESP_OKAY);
        axi_rd(OFF_COUNT, {rej[15:0], acc[15:0]}, RESP_OKAY);
        close_out();
    end

    // the tests need about seven hundred cycles; ten thousand cycles means a hang
    initial begin
        #40000;
        failures++;
        close_out();
    end
endmodule
`default_nettype wire
